// >>> io_expander_pkg.sv
package io_expander_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFF       = 12'h350;
  localparam logic [11:0] ADDR0_OFF      = 12'h354;
  localparam logic [11:0] ADDR1_OFF      = 12'h358;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h370;
  localparam logic [11:0] IRQ_MASK_OFF   = 12'h374;

  // Control register fields
  localparam int PIN_LSB     = 0;
  localparam int PIN_W       = 16;
  localparam int REFRESH_BIT = 24;
  localparam int TEST_BIT    = 25;
  localparam int SEL_LSB     = 26;
  localparam int SEL_W       = 4;
  localparam int DONE_BIT    = 31;

  // Address register fields (7-bit bus address per expander)
  localparam int ADDR_W    = 7;
  localparam int ADDR_LSB0 = 1;
  localparam int ADDR_LSB1 = 9;
  localparam int ADDR_LSB2 = 17;

  // Select codes and slots
  localparam int         NUM_SLOTS = 4;
  localparam logic [3:0] SEL_EXP0  = 4'h0;
  localparam logic [3:0] SEL_EXP1  = 4'h1;
  localparam logic [3:0] SEL_EXP2  = 4'h2;
  localparam logic [3:0] SEL_EXP4  = 4'h4;

  // Interrupt status bits
  localparam int IRQ_W        = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_NACK_BIT = 1;

  // Reset values
  localparam logic [3:0]        SEL_RST  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [IRQ_W-1:0]  MASK_RST = 2'h0;

  // Bus timing: quarter of a 100 kHz bit, a least time so rounded up
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SMB_QUARTER_NS = 2500;
  localparam int QUARTER_CYC    = (SMB_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_BYTES    = 6;

  typedef enum logic [3:0] {
    E_IDLE  = 4'b0001,
    E_START = 4'b0010,
    E_BIT   = 4'b0100,
    E_STOP  = 4'b1000
  } eng_state_t;

endpackage : io_expander_pkg

// >>> smbus_frame_engine.sv
module smbus_frame_engine (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Request and answer
  input  wire logic        start_i,
  input  wire logic [6:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             nack_o,
  output logic [15:0]      rdata_o,
  // Open-drain bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o
);

  io_expander_pkg::eng_state_t st_q;
  logic [7:0]  cnt_q;
  logic [1:0]  ph_q;
  logic [2:0]  byte_q;
  logic [3:0]  bit_q;
  logic [6:0]  addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        nack_q;
  logic        scl_q;
  logic        sda_q;
  logic        done_q;
  logic [1:0]  scl_sync_q;
  logic [1:0]  sda_sync_q;
  logic        tick;

  function automatic logic tx_level(input logic [2:0] b, input logic [3:0] n,
                                    input logic [6:0] a, input logic [15:0] w);
    logic [7:0] v;
    v = 8'hFF;
    case (b)
      3'h0:    v = {a, 1'b0};
      3'h1:    v = w[7:0];
      3'h2:    v = w[15:8];
      3'h3:    v = {a, 1'b1};
      default: v = 8'hFF;
    endcase
    if (n == 4'h8)
      tx_level = (b == 3'h4) ? 1'b0 : 1'b1;
    else
      tx_level = v[3'(4'h7 - n)];
  endfunction : tx_level

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Quarter-bit divider; a target holding the clock low stretches the phase
  assign tick = (cnt_q == 8'(io_expander_pkg::QUARTER_CYC - 1)) && !(scl_q && !scl_sync_q[1]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || st_q == io_expander_pkg::E_IDLE)
      cnt_q <= 8'h00;
    else if (tick)
      cnt_q <= 8'h00;
    else if (cnt_q != 8'(io_expander_pkg::QUARTER_CYC - 1))
      cnt_q <= cnt_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame: start, addr+W, out lo, out hi, restart, addr+R, in lo, in hi, stop
  always_ff @(posedge clk_i)
  begin
    done_q <= 1'b0;
    if (rst_i)
    begin
      st_q    <= io_expander_pkg::E_IDLE;
      ph_q    <= 2'h0;
      byte_q  <= 3'h0;
      bit_q   <= 4'h0;
      addr_q  <= 7'h00;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      nack_q  <= 1'b0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end
    else if (st_q == io_expander_pkg::E_IDLE)
    begin
      if (start_i)
      begin
        st_q    <= io_expander_pkg::E_START;
        addr_q  <= addr_i;
        wdata_q <= wdata_i;
        nack_q  <= 1'b0;
        byte_q  <= 3'h0;
        bit_q   <= 4'h0;
        ph_q    <= 2'h0;
      end
    end
    else if (tick)
    begin
      ph_q <= ph_q + 2'h1;
      case (st_q)
        io_expander_pkg::E_START:
        begin
          case (ph_q)
            2'h0:    sda_q <= 1'b1;
            2'h1:    scl_q <= 1'b1;
            2'h2:    sda_q <= 1'b0;
            default:
            begin
              scl_q <= 1'b0;
              bit_q <= 4'h0;
              st_q  <= io_expander_pkg::E_BIT;
            end
          endcase
        end
        io_expander_pkg::E_BIT:
        begin
          case (ph_q)
            2'h0:    sda_q <= tx_level(byte_q, bit_q, addr_q, wdata_q);
            2'h1:    scl_q <= 1'b1;
            2'h2:
            begin
              if (bit_q != 4'h8 && byte_q >= 3'h4)
                rdata_q <= {rdata_q[14:0], sda_sync_q[1]};
              if (bit_q == 4'h8 && byte_q < 3'h4 && sda_sync_q[1])
                nack_q <= 1'b1;
            end
            default:
            begin
              scl_q <= 1'b0;
              if (bit_q == 4'h8)
              begin
                bit_q <= 4'h0;
                if (byte_q == 3'h2)
                  st_q <= io_expander_pkg::E_START;
                else if (byte_q == 3'(io_expander_pkg::FRAME_BYTES - 1))
                  st_q <= io_expander_pkg::E_STOP;
                byte_q <= byte_q + 3'h1;
              end
              else
                bit_q <= bit_q + 4'h1;
            end
          endcase
        end
        io_expander_pkg::E_STOP:
        begin
          case (ph_q)
            2'h0:    sda_q <= 1'b0;
            2'h1:    scl_q <= 1'b1;
            2'h2:    sda_q <= 1'b1;
            default:
            begin
              st_q   <= io_expander_pkg::E_IDLE;
              done_q <= 1'b1;
            end
          endcase
        end
        default: st_q <= io_expander_pkg::E_IDLE;
      endcase
    end
  end

  // Input bytes arrive low byte first, each MSB first
  assign rdata_o    = {rdata_q[7:0], rdata_q[15:8]};
  assign busy_o     = (st_q != io_expander_pkg::E_IDLE);
  assign done_o     = done_q;
  assign nack_o     = nack_q;
  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_n_o = scl_q;
  assign sda_oe_n_o = sda_q;

endmodule : smbus_frame_engine

// >>> io_expander_access_control.sv
module io_expander_access_control (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // Interrupt
  output logic                   irq_o,
  // Core side, one 16-bit lane per expander slot
  input  wire logic [3:0][15:0]  core_out_i,
  input  wire logic [3:0][15:0]  pin_is_input_i,
  output logic [3:0][15:0]       expander_in_o,
  // Master bus pins
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n_o
);

  logic                                  ack_q;
  logic [31:0]                           dat_q;
  logic [3:0]                            sel_q;
  logic                                  test_q;
  logic                                  done_q;
  logic [3:0][15:0]                      sw_out_q;
  logic [3:0][15:0]                      in_val_q;
  logic [3:0][15:0]                      out_sent_q;
  logic [3:0][io_expander_pkg::ADDR_W-1:0] addr_q;
  logic [3:0]                            pend_q;
  logic [3:0]                            dreq_q;
  logic                                  run_dreq_q;
  logic [1:0]                            run_slot_q;
  logic [io_expander_pkg::IRQ_W-1:0]     irq_st_q;
  logic [io_expander_pkg::IRQ_W-1:0]     irq_mask_q;

  logic        acc;
  logic        wr;
  logic        hit_ctrl;
  logic        hit_a0;
  logic        hit_a1;
  logic        hit_st;
  logic        hit_mk;
  logic [31:0] lane_m;
  logic [2:0]  sel_dec;
  logic [2:0]  new_dec;
  logic        pin_wr;
  logic        done_clr;
  logic        done_set;
  logic [3:0]  set_pend;
  logic [3:0]  set_dreq;
  logic [3:0][15:0] drive_val;
  logic [1:0]  cur;
  logic        go;
  logic [15:0] eng_wdata;
  logic        eng_busy;
  logic        eng_done;
  logic        eng_nack;
  logic [15:0] eng_rdata;
  logic [31:0] rd_mux;

  // Returns {valid, slot}
  function automatic logic [2:0] slot_of(input logic [3:0] code);
    case (code)
      io_expander_pkg::SEL_EXP0: slot_of = 3'b100;
      io_expander_pkg::SEL_EXP1: slot_of = 3'b101;
      io_expander_pkg::SEL_EXP2: slot_of = 3'b110;
      io_expander_pkg::SEL_EXP4: slot_of = 3'b111;
      default:                   slot_of = 3'b000;
    endcase
  endfunction : slot_of

  function automatic logic [15:0] pin_view(input logic [15:0] in_v, input logic [15:0] out_v,
                                           input logic [15:0] dir);
    pin_view = (in_v & dir) | (out_v & ~dir);
  endfunction : pin_view

  function automatic logic hit(input logic [11:0] adr, input logic [11:0] off);
    hit = (adr[11:2] == off[11:2]);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode: every access answers one cycle after it is presented
  assign acc      = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr       = acc && wb_we_i;
  assign hit_ctrl = hit(wb_adr_i, io_expander_pkg::CTRL_OFF);
  assign hit_a0   = hit(wb_adr_i, io_expander_pkg::ADDR0_OFF);
  assign hit_a1   = hit(wb_adr_i, io_expander_pkg::ADDR1_OFF);
  assign hit_st   = hit(wb_adr_i, io_expander_pkg::IRQ_STATUS_OFF);
  assign hit_mk   = hit(wb_adr_i, io_expander_pkg::IRQ_MASK_OFF);
  assign lane_m   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign sel_dec  = slot_of(sel_q);
  assign new_dec  = wb_sel_i[3] ? slot_of(wb_dat_i[io_expander_pkg::SEL_LSB +: 4]) : sel_dec;
  assign pin_wr   = wr && hit_ctrl && test_q && sel_dec[2] && (|wb_sel_i[1:0]);
  assign done_clr = wr && hit_ctrl && wb_sel_i[3] && wb_dat_i[io_expander_pkg::DONE_BIT];
  assign done_set = eng_done && run_dreq_q && sel_dec[2] && (sel_dec[1:0] == run_slot_q);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= acc;
      if (acc)
        dat_q <= wb_we_i ? 32'h0000_0000 : rd_mux;
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
    begin
      // Refresh trigger and reserved bits stay zero
      rd_mux[io_expander_pkg::DONE_BIT] = done_q;
      rd_mux[io_expander_pkg::SEL_LSB +: io_expander_pkg::SEL_W] = sel_q;
      rd_mux[io_expander_pkg::TEST_BIT] = test_q;
      if (sel_dec[2])
        rd_mux[io_expander_pkg::PIN_LSB +: io_expander_pkg::PIN_W] =
          pin_view(in_val_q[sel_dec[1:0]], out_sent_q[sel_dec[1:0]],
                   pin_is_input_i[sel_dec[1:0]]);
    end
    else if (hit_a0)
    begin
      rd_mux[io_expander_pkg::ADDR_LSB0 +: io_expander_pkg::ADDR_W] = addr_q[0];
      rd_mux[io_expander_pkg::ADDR_LSB1 +: io_expander_pkg::ADDR_W] = addr_q[1];
      rd_mux[io_expander_pkg::ADDR_LSB2 +: io_expander_pkg::ADDR_W] = addr_q[2];
    end
    else if (hit_a1)
      rd_mux[io_expander_pkg::ADDR_LSB0 +: io_expander_pkg::ADDR_W] = addr_q[3];
    else if (hit_st)
      rd_mux[io_expander_pkg::IRQ_W-1:0] = irq_st_q;
    else if (hit_mk)
      rd_mux[io_expander_pkg::IRQ_W-1:0] = irq_mask_q;
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_q  <= io_expander_pkg::SEL_RST;
      test_q <= 1'b0;
    end
    else if (wr && hit_ctrl && wb_sel_i[3])
    begin
      sel_q  <= wb_dat_i[io_expander_pkg::SEL_LSB +: io_expander_pkg::SEL_W];
      test_q <= wb_dat_i[io_expander_pkg::TEST_BIT];
    end
  end

  // Set beats clear so a frame ending in the clearing cycle is not lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_q <= 1'b0;
    else if (done_set)
      done_q <= 1'b1;
    else if (done_clr)
      done_q <= 1'b0;
  end

  // Test values only land in output bits; input bits stay read-only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sw_out_q <= '0;
    else if (pin_wr)
      sw_out_q[sel_dec[1:0]] <= (sw_out_q[sel_dec[1:0]] & ~(lane_m[15:0] &
        ~pin_is_input_i[sel_dec[1:0]])) | (wb_dat_i[15:0] & lane_m[15:0] &
        ~pin_is_input_i[sel_dec[1:0]]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      addr_q <= {io_expander_pkg::NUM_SLOTS{io_expander_pkg::ADDR_RST}};
    else
    begin
      if (wr && hit_a0 && wb_sel_i[0])
        addr_q[0] <= wb_dat_i[io_expander_pkg::ADDR_LSB0 +: io_expander_pkg::ADDR_W];
      if (wr && hit_a0 && wb_sel_i[1])
        addr_q[1] <= wb_dat_i[io_expander_pkg::ADDR_LSB1 +: io_expander_pkg::ADDR_W];
      if (wr && hit_a0 && wb_sel_i[2])
        addr_q[2] <= wb_dat_i[io_expander_pkg::ADDR_LSB2 +: io_expander_pkg::ADDR_W];
      if (wr && hit_a1 && wb_sel_i[0])
        addr_q[3] <= wb_dat_i[io_expander_pkg::ADDR_LSB0 +: io_expander_pkg::ADDR_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transaction requests per slot
  always_comb
  begin
    set_pend = 4'h0;
    set_dreq = 4'h0;
    for (int s = 0; s < io_expander_pkg::NUM_SLOTS; s++)
    begin
      drive_val[s] = (test_q && sel_dec[2] && sel_dec[1:0] == 2'(s)) ?
                     sw_out_q[s] : core_out_i[s];
      // Core changes go out without the flag; a slot launching now already carries them
      if (((drive_val[s] ^ out_sent_q[s]) & ~pin_is_input_i[s]) != '0 && !(go && cur == 2'(s)))
        set_pend[s] = 1'b1;
    end
    if (wr && hit_ctrl && wb_sel_i[3] && wb_dat_i[io_expander_pkg::REFRESH_BIT] && new_dec[2])
      set_dreq[new_dec[1:0]] = 1'b1;
    if (pin_wr)
      set_dreq[sel_dec[1:0]] = 1'b1;
    if (wr && hit_a0)
      set_dreq[2:0] = set_dreq[2:0] | wb_sel_i[2:0];
    if (wr && hit_a1 && wb_sel_i[0])
      set_dreq[3] = 1'b1;
    set_pend = set_pend | set_dreq;
  end

  always_comb
  begin
    cur = 2'h0;
    for (int s = io_expander_pkg::NUM_SLOTS - 1; s >= 0; s--)
      if (pend_q[s])
        cur = 2'(s);
  end

  assign go        = !eng_busy && (|pend_q);
  assign eng_wdata = (drive_val[cur] & ~pin_is_input_i[cur]) | pin_is_input_i[cur];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_q     <= 4'h0;
      dreq_q     <= 4'h0;
      run_dreq_q <= 1'b0;
      run_slot_q <= 2'h0;
    end
    else
    begin
      pend_q <= (pend_q & ~(go ? 4'(1) << cur : 4'h0)) | set_pend;
      dreq_q <= (dreq_q & ~(go ? 4'(1) << cur : 4'h0)) | set_dreq;
      if (go)
      begin
        run_slot_q <= cur;
        run_dreq_q <= dreq_q[cur] || set_dreq[cur];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_val_q   <= '0;
      out_sent_q <= '0;
    end
    else
    begin
      if (go)
        out_sent_q[cur] <= eng_wdata;
      if (eng_done)
        in_val_q[run_slot_q] <= eng_rdata;
    end
  end

  assign expander_in_o = in_val_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt: sticky events, write one to clear, set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_st_q   <= '0;
      irq_mask_q <= io_expander_pkg::MASK_RST;
    end
    else
    begin
      irq_st_q <= (irq_st_q & ~((wr && hit_st && wb_sel_i[0]) ?
                  wb_dat_i[io_expander_pkg::IRQ_W-1:0] : 2'h0)) |
                  {eng_done && eng_nack, done_set};
      if (wr && hit_mk && wb_sel_i[0])
        irq_mask_q <= wb_dat_i[io_expander_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_st_q & irq_mask_q);

  smbus_frame_engine u_engine (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (go),
    .addr_i     (addr_q[cur]),
    .wdata_i    (eng_wdata),
    .busy_o     (eng_busy),
    .done_o     (eng_done),
    .nack_o     (eng_nack),
    .rdata_o    (eng_rdata),
    .scl_i      (scl_i),
    .scl_o      (scl_o),
    .scl_oe_n_o (scl_oe_n_o),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_n_o (sda_oe_n_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic rd_ctrl;
  assign rd_ctrl = acc && !wb_we_i && hit_ctrl;

  sequence s_reload_req;
    wr && hit_ctrl && wb_sel_i[3] && wb_dat_i[io_expander_pkg::REFRESH_BIT] && new_dec[2];
  endsequence
  sequence s_frame_end;
    eng_done && run_dreq_q && sel_dec[2] && sel_dec[1:0] == run_slot_q;
  endsequence

  property p_sel4_view;
    (rd_ctrl && sel_q == io_expander_pkg::SEL_EXP4) |=>
      wb_dat_o[15:0] == (($past(in_val_q[3]) & $past(pin_is_input_i[3])) |
                         ($past(out_sent_q[3]) & ~$past(pin_is_input_i[3])));
  endproperty
  a_sel4_view: assert property (p_sel4_view) else $error("pin view of slot 3 wrong");
  property p_in_capture;
    eng_done |=> in_val_q[$past(run_slot_q)] == $past(eng_rdata);
  endproperty
  a_in_capture: assert property (p_in_capture) else $error("input capture lost");
  property p_pin_ignored;
    (wr && hit_ctrl && !test_q) |=> $stable(sw_out_q);
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin write not ignored");
  property p_test_drive;
    (go && test_q && sel_dec[2] && cur == sel_dec[1:0]) |->
      (eng_wdata & ~pin_is_input_i[cur]) == (sw_out_q[cur] & ~pin_is_input_i[cur]);
  endproperty
  a_test_drive: assert property (p_test_drive) else $error("test values not sent");
  property p_inputs_ro;
    1'b1 |=> ((sw_out_q ^ $past(sw_out_q)) & $past(pin_is_input_i)) == '0;
  endproperty
  a_inputs_ro: assert property (p_inputs_ro) else $error("input bit written");
  property p_reload;
    s_reload_req |=> pend_q[$past(new_dec[1:0])] || eng_busy;
  endproperty
  a_reload: assert property (p_reload) else $error("refresh not queued");
  property p_refresh_zero;
    rd_ctrl |=> !wb_dat_o[io_expander_pkg::REFRESH_BIT] && wb_ack_o;
  endproperty
  a_refresh_zero: assert property (p_refresh_zero) else $error("trigger reads one");
  property p_reserved_zero;
    rd_ctrl |=> wb_dat_o[23:16] == 8'h00 && !wb_dat_o[30];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved nonzero");
  property p_done_set;
    s_frame_end |=> done_q;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set");
  property p_done_hold;
    (done_q && !done_clr) |=> done_q;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done lost");
  property p_addr_use;
    go |-> ##1 u_engine.addr_q == $past(addr_q[cur]);
  endproperty
  a_addr_use: assert property (p_addr_use) else $error("wrong bus address");

endmodule : io_expander_access_control

// >>> exp_target.sv
module exp_target (
  // Bus lines
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        stretch_i,
  output logic             scl_low_o,
  output logic             sda_low_o,
  // Data served and seen
  input  wire logic [15:0] in_val_i,
  output logic [6:0]       addr_o,
  output logic [15:0]      out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int         n = 99;
  logic [7:0] sh;
  logic       rd;
  initial sda_low_o = 1'h0;
  initial scl_low_o = 1'h0;
  // Start or repeated start restarts the count, stop parks it
  always @(negedge sda_i) if (scl_i) n = 0;
  always @(posedge sda_i) if (scl_i) n = 99;
  always @(posedge scl_i)
  begin
    n++;
    sh = {sh[6:0], sda_i};
    if (n == 8) rd = sh[0];
    if (n == 8) addr_o <= sh[7:1];
    if (!rd && n == 17) out_o[7:0] <= sh;
    if (!rd && n == 26) out_o[15:8] <= sh;
  end
  // Released bits float high through the pull-up
  always @(negedge scl_i)
    if (n == 8 || (!rd && (n == 17 || n == 26))) sda_low_o <= 1'h1;
    else if (rd && n >= 9 && n <= 16) sda_low_o <= !in_val_i[16-n];
    else if (rd && n >= 18 && n <= 25) sda_low_o <= !in_val_i[33-n];
    else sda_low_o <= 1'h0;
  // A slow target holds the clock low after the address
  always @(negedge scl_i)
    if (stretch_i && n == 9)
    begin
      scl_low_o = 1'h1;
      #3000 scl_low_o = 1'h0;
    end
endmodule : exp_target

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk_i = 1'h0;
  logic             rst_i = 1'h1;
  logic             cyc = '0, stb = '0, we = '0, ack, irq, stretch = '0;
  logic             scl_o, scl_oe_n, sda_o, sda_oe_n, t_low, t_sclow;
  logic [11:0]      adr = '0;
  logic [3:0]       sel = '0;
  logic [31:0]      dat = '0, rdat, q, rs = 32'h17;
  logic [3:0]       codes [5] = '{4'h3, 4'h1, 4'h2, 4'h4, 4'h0};
  logic [3:0][15:0] inp = '0, xin;
  logic [15:0]      t_out, in_val = '0, w;
  logic [6:0]       t_addr, a;
  int               failures = 0, cmp_count = 0;
  wire              scl = !((!scl_oe_n && !scl_o) || t_sclow);
  wire              sda = !((!sda_oe_n && !sda_o) || t_low);
  io_expander_access_control u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .core_out_i('0), .pin_is_input_i(inp),
    .expander_in_o(xin), .scl_i(scl), .scl_o, .scl_oe_n_o(scl_oe_n), .sda_i(sda),
    .sda_o, .sda_oe_n_o(sda_oe_n));
  exp_target u_tgt (.scl_i(scl), .sda_i(sda), .stretch_i(stretch), .scl_low_o(t_sclow),
    .sda_low_o(t_low), .in_val_i(in_val), .addr_o(t_addr), .out_o(t_out));
  initial forever #10 clk_i = !clk_i;
  ////////////////////////////////////////
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  function logic [15:0] pin_exp(input logic [15:0] o);
    return (in_val & inp[0]) | (o & ~inp[0]);
  endfunction : pin_exp
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task rw(input logic w_en, input logic [11:0] ad, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w_en;
    adr <= ad;
    sel <= s;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : rw
  // Polls the flag the way software would
  task wait_done;
    q = '0;
    for (int i = 0; i < 20000 && q[31] !== 1'h1; i++)
      rw(1'h0, io_expander_pkg::CTRL_OFF, 4'hF, '0);
  endtask : wait_done
  task close_out;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (95000) @(posedge clk_i);
    failures++;
    close_out();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    in_val = 16'(rnd());
    w = 16'(rnd());
    a = 7'(rnd());
    inp[0] <= 16'(rnd());
    rw(1'h1, io_expander_pkg::CTRL_OFF, 4'hF, 32'h40FF_FFFF);
    rw(1'h0, io_expander_pkg::CTRL_OFF, 4'hF, '0);
    chk(q, '0);
    foreach (codes[i])
    begin
      rw(1'h1, io_expander_pkg::CTRL_OFF, 4'h8, 32'(codes[i]) << 26);
      rw(1'h0, io_expander_pkg::CTRL_OFF, 4'hF, '0);
      chk(q, 32'(codes[i]) << 26);
    end
    rw(1'h0, 12'h3F0, 4'hF, '0);
    chk(q, '0);
    rw(1'h1, io_expander_pkg::ADDR0_OFF, 4'h1, 32'(a) << 1);
    wait_done();
    chk(q, 32'h8000_0000 | pin_exp(16'h0));
    chk(t_addr, a);
    chk(irq, 1'h0);
    rw(1'h1, io_expander_pkg::IRQ_MASK_OFF, 4'hF, 32'h1);
    chk(irq, 1'h1);
    rw(1'h1, io_expander_pkg::CTRL_OFF, 4'h8, '0);
    rw(1'h0, io_expander_pkg::CTRL_OFF, 4'hF, '0);
    chk(q[31], 1'h1);
    rw(1'h1, io_expander_pkg::CTRL_OFF, 4'h8, 32'h8000_0000);
    rw(1'h1, io_expander_pkg::IRQ_STATUS_OFF, 4'hF, 32'h1);
    chk(irq, 1'h0);
    rw(1'h1, io_expander_pkg::CTRL_OFF, 4'hF, 32'h0200_0000);
    rw(1'h1, io_expander_pkg::CTRL_OFF, 4'hF, 32'h0200_0000 | w);
    wait_done();
    chk(t_out, w | inp[0]);
    chk(q, 32'h8200_0000 | pin_exp(w));
    chk(irq, 1'h1);
    rw(1'h1, io_expander_pkg::CTRL_OFF, 4'h8, 32'h8200_0000);
    in_val = 16'(rnd());
    stretch = 1'h1;
    rw(1'h1, io_expander_pkg::CTRL_OFF, 4'h8, 32'h0300_0000);
    wait_done();
    chk(q, 32'h8200_0000 | pin_exp(w));
    chk(xin[0] & inp[0], in_val & inp[0]);
    close_out();
  end
endmodule : tb_top
